// >>> rtl/nti_pkg.sv
`default_nettype none
package nti_pkg;

  // Clock and power-up timing
  localparam int unsigned NTI_CLK_PERIOD_NS    = 10;
  localparam int unsigned NTI_POWER_UP_MAX_NS  = 1_000_000;
  localparam int unsigned NTI_POWER_UP_CYCLES  =
    (NTI_POWER_UP_MAX_NS / NTI_CLK_PERIOD_NS) < 1 ? 1 : (NTI_POWER_UP_MAX_NS / NTI_CLK_PERIOD_NS);
  localparam int unsigned NTI_PWR_CNT_W        = 17;

  // Widths
  localparam int unsigned NTI_UNIT_IDX_W       = 4;
  localparam int unsigned NTI_NUM_UNITS        = 4;

  // First-cycle opcodes
  localparam logic [7:0] NTI_OP_READ           = 8'h00;
  localparam logic [7:0] NTI_OP_ERASE          = 8'h60;
  localparam logic [7:0] NTI_OP_STATUS         = 8'h70;
  localparam logic [7:0] NTI_OP_STATUS_ENH     = 8'h78;
  localparam logic [7:0] NTI_OP_PROGRAM        = 8'h80;
  localparam logic [7:0] NTI_OP_READ_ID        = 8'h90;
  localparam logic [7:0] NTI_OP_VOL_SELECT     = 8'hE1;
  localparam logic [7:0] NTI_OP_ODT_CFG        = 8'hE2;
  localparam logic [7:0] NTI_OP_PARAM_PAGE     = 8'hEC;
  localparam logic [7:0] NTI_OP_UNIQUE_ID      = 8'hED;
  localparam logic [7:0] NTI_OP_GET_FEAT       = 8'hEE;
  localparam logic [7:0] NTI_OP_SET_FEAT       = 8'hEF;
  localparam logic [7:0] NTI_OP_RESET_UNIT     = 8'hFA;
  localparam logic [7:0] NTI_OP_RESET_SYNC     = 8'hFC;
  localparam logic [7:0] NTI_OP_RESET          = 8'hFF;

  // Register byte offsets
  localparam logic [3:0] NTI_REG_CTRL          = 4'h0;
  localparam logic [3:0] NTI_REG_STATUS        = 4'h4;
  localparam logic [3:0] NTI_REG_EXEC          = 4'h8;

  // Control register fields
  localparam int unsigned NTI_CTRL_COL_CHG     = 0;
  localparam int unsigned NTI_CTRL_COL_CHG_ENH = 1;
  localparam int unsigned NTI_CTRL_COPYBACK    = 2;
  localparam int unsigned NTI_CTRL_ENH_REQ     = 3;
  localparam int unsigned NTI_CTRL_UNIT_LSB    = 4;

  // Status register fields
  localparam int unsigned NTI_STAT_STATE_LSB   = 0;
  localparam int unsigned NTI_STAT_STATUS_OUT  = 5;
  localparam int unsigned NTI_STAT_RB          = 6;
  localparam int unsigned NTI_STAT_WP          = 7;
  localparam int unsigned NTI_STAT_OPCODE_LSB  = 8;
  localparam int unsigned NTI_STAT_RESUME_LSB  = 16;

  // Exec register fields
  localparam int unsigned NTI_EXEC_DONE        = 0;
  localparam int unsigned NTI_EXEC_TO_READ     = 1;

  // Target states
  typedef enum logic [4:0] {
    st_power_up,
    st_power_up_ready,
    st_exec_rst_power_up,
    st_idle,
    st_idle_read,
    st_cmd_decode,
    st_wp_update,
    st_readiness_update,
    st_exec_reset,
    st_exec_reset_sync,
    st_exec_reset_unit,
    st_exec_read_id,
    st_exec_param_page,
    st_exec_unique_id,
    st_exec_program,
    st_exec_erase,
    st_exec_read,
    st_exec_set_feat,
    st_exec_get_feat,
    st_exec_status,
    st_exec_status_enh,
    st_exec_vol_select,
    st_exec_odt_cfg
  } nti_state_e;

  // Command cycle from the host interface logic
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } nti_cmd_s;

  // Whole state of the target machine
  typedef struct packed {
    nti_state_e                 state;
    nti_state_e                 resume_state;
    logic                       ready_busy;
    logic                       return_status_on_read;
    logic                       column_change_allowed;
    logic                       column_change_enh_allowed;
    logic                       copyback_active;
    logic [NTI_UNIT_IDX_W-1:0]  selected_unit_index;
    logic [7:0]                 last_opcode_record;
    logic                       enh_status_required;
    logic [7:0]                 cmd_opcode;
    logic                       wp_meta;
    logic                       wp_sync;
    logic                       wp_seen;
    logic                       wp_to_units;
    logic [NTI_NUM_UNITS-1:0]   units_seen;
    logic [NTI_PWR_CNT_W-1:0]   power_cnt;
    logic                       bus_wait;
    logic [31:0]                bus_rdata;
  } nti_state_s;

endpackage
`default_nettype wire

// >>> rtl/nti_target_fsm.sv
// Summary of operation
// - Hold state when no exit condition holds
// - Status-output flag, clear at power-up
// - Two column-change permission flags, clear initially
// - Copyback-active flag, clear at power-up
// - Selected unit index, zero at power-up
// - Record first opcode, except status reads
// - Resume-state register after protect or readiness update
// - Flag forcing next status read to enhanced
// - Power-up state drives ready/busy low
// - Leave power-up within one millisecond
// - Power-up ready advances only on reset
// - Power-up ready drives ready/busy high
// - Idle entry clears copyback, resume becomes idle
// - Idle priority: protect, readiness, then command
// - Protected program or erase returns to idle
// - Unprotected program or erase enters execution
// - Identify, parameter page, unique id dispatch
// - Plain and enhanced status read dispatch
// - Decode updates status flag, clears enhanced flag on a non-status command while ready
// - Protect handling forwards level, returns correctly
// - Ready/busy is AND of unit bits
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module nti_target_fsm
  import nti_pkg::*;
#(
  parameter int unsigned POWER_UP_CYCLES = NTI_POWER_UP_CYCLES
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire nti_cmd_s                   cmd_i,
  input  wire logic                       wp_n_i,
  input  wire logic [NTI_NUM_UNITS-1:0]   unit_ready_bit_i,
  input  wire logic [3:0]                 avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  output logic [31:0]                     avs_readdata_o,
  output logic                            avs_waitrequest_o,
  output logic                            ready_busy_o,
  output logic                            wp_level_to_units_o,
  output logic                            return_status_on_read_o,
  output logic                            column_change_allowed_o,
  output logic                            column_change_enh_allowed_o,
  output logic                            copyback_active_o,
  output logic [NTI_UNIT_IDX_W-1:0]       selected_unit_index_o,
  output logic [7:0]                      last_opcode_record_o,
  output logic                            enh_status_required_o,
  output nti_state_e                      state_o
);

  localparam logic [NTI_PWR_CNT_W-1:0] PWR_LAST = NTI_PWR_CNT_W'(POWER_UP_CYCLES - 1);

  nti_state_s s_r;
  nti_state_s s_nxt;

  // Next-state logic for the whole block
  always_comb
  begin
    logic [31:0] rd_word;
    logic        wr_ack;
    logic        exec_done;
    logic        exec_to_read;
    logic        is_status_op;
    rd_word      = 32'h0000_0000;
    wr_ack       = avs_write_i && !s_r.bus_wait;
    exec_done    = 1'b0;
    exec_to_read = 1'b0;
    is_status_op = 1'b0;
    s_nxt        = s_r;

    // Write-protect pin synchroniser
    s_nxt.wp_meta = wp_n_i;
    s_nxt.wp_sync = s_r.wp_meta;

    // Register read mux, unmapped reads as zero
    case (avs_address_i)
      NTI_REG_CTRL:
      begin
        rd_word[NTI_CTRL_COL_CHG]     = s_r.column_change_allowed;
        rd_word[NTI_CTRL_COL_CHG_ENH] = s_r.column_change_enh_allowed;
        rd_word[NTI_CTRL_COPYBACK]    = s_r.copyback_active;
        rd_word[NTI_CTRL_ENH_REQ]     = s_r.enh_status_required;
        rd_word[NTI_CTRL_UNIT_LSB +: NTI_UNIT_IDX_W] = s_r.selected_unit_index;
      end
      NTI_REG_STATUS:
      begin
        rd_word[NTI_STAT_STATE_LSB +: 5]  = s_r.state;
        rd_word[NTI_STAT_STATUS_OUT]      = s_r.return_status_on_read;
        rd_word[NTI_STAT_RB]              = s_r.ready_busy;
        rd_word[NTI_STAT_WP]              = s_r.wp_to_units;
        rd_word[NTI_STAT_OPCODE_LSB +: 8] = s_r.last_opcode_record;
        rd_word[NTI_STAT_RESUME_LSB +: 5] = s_r.resume_state;
      end
      default:
      begin
        rd_word = 32'h0000_0000;
      end
    endcase

    // Bus handshake: one wait cycle, then one answer cycle
    s_nxt.bus_wait = 1'b1;
    if ((avs_read_i || avs_write_i) && s_r.bus_wait)
    begin
      s_nxt.bus_wait  = 1'b0;
      s_nxt.bus_rdata = rd_word;
    end

    // Exec register write ends an execute state
    if (wr_ack && avs_address_i == NTI_REG_EXEC)
    begin
      exec_done    = avs_writedata_i[NTI_EXEC_DONE];
      exec_to_read = avs_writedata_i[NTI_EXEC_TO_READ];
    end

    // Opcode capture and last-opcode record
    if (cmd_i.valid)
    begin
      s_nxt.cmd_opcode = cmd_i.opcode;
      if (cmd_i.opcode != NTI_OP_STATUS && cmd_i.opcode != NTI_OP_STATUS_ENH)
      begin
        s_nxt.last_opcode_record = cmd_i.opcode;
      end
    end
    is_status_op = (s_r.cmd_opcode == NTI_OP_STATUS) || (s_r.cmd_opcode == NTI_OP_STATUS_ENH);

    // Target state machine; unlisted conditions keep the state
    case (s_r.state)
      st_power_up:
      begin
        s_nxt.ready_busy = 1'b0;
        s_nxt.power_cnt  = s_r.power_cnt + NTI_PWR_CNT_W'(1);
        if (s_r.power_cnt >= PWR_LAST)
        begin
          s_nxt.state      = st_power_up_ready;
          s_nxt.ready_busy = 1'b1;
        end
      end
      st_power_up_ready:
      begin
        if (cmd_i.valid && cmd_i.opcode == NTI_OP_RESET)
        begin
          s_nxt.state = st_exec_rst_power_up;
        end
      end
      st_idle, st_idle_read:
      begin
        if (s_r.wp_sync != s_r.wp_seen)
        begin
          s_nxt.state = st_wp_update;
        end
        else if (unit_ready_bit_i != s_r.units_seen)
        begin
          s_nxt.state = st_readiness_update;
        end
        else if (cmd_i.valid)
        begin
          s_nxt.state = st_cmd_decode;
        end
      end
      st_cmd_decode:
      begin
        s_nxt.return_status_on_read = is_status_op;
        if (s_r.ready_busy && !is_status_op)
        begin
          s_nxt.enh_status_required = 1'b0;
        end
        case (s_r.cmd_opcode)
          NTI_OP_PROGRAM:     s_nxt.state = s_r.wp_sync ? st_exec_program : st_idle;
          NTI_OP_ERASE:       s_nxt.state = s_r.wp_sync ? st_exec_erase : st_idle;
          NTI_OP_RESET:       s_nxt.state = st_exec_reset;
          NTI_OP_RESET_SYNC:  s_nxt.state = st_exec_reset_sync;
          NTI_OP_RESET_UNIT:  s_nxt.state = st_exec_reset_unit;
          NTI_OP_READ_ID:     s_nxt.state = st_exec_read_id;
          NTI_OP_PARAM_PAGE:  s_nxt.state = st_exec_param_page;
          NTI_OP_UNIQUE_ID:   s_nxt.state = st_exec_unique_id;
          NTI_OP_READ:        s_nxt.state = st_exec_read;
          NTI_OP_SET_FEAT:    s_nxt.state = st_exec_set_feat;
          NTI_OP_GET_FEAT:    s_nxt.state = st_exec_get_feat;
          NTI_OP_STATUS:      s_nxt.state = st_exec_status;
          NTI_OP_STATUS_ENH:  s_nxt.state = st_exec_status_enh;
          NTI_OP_VOL_SELECT:  s_nxt.state = st_exec_vol_select;
          NTI_OP_ODT_CFG:     s_nxt.state = st_exec_odt_cfg;
          default:            s_nxt.state = st_idle;
        endcase
      end
      st_wp_update:
      begin
        s_nxt.wp_seen     = s_r.wp_sync;
        s_nxt.wp_to_units = s_r.wp_sync;
        s_nxt.state       = (s_r.resume_state == st_idle_read) ? st_idle_read : st_idle;
      end
      st_readiness_update:
      begin
        s_nxt.units_seen = unit_ready_bit_i;
        s_nxt.ready_busy = &unit_ready_bit_i;
        s_nxt.state      = s_r.resume_state;
      end
      st_exec_rst_power_up, st_exec_reset, st_exec_reset_sync, st_exec_reset_unit,
      st_exec_read_id, st_exec_param_page, st_exec_unique_id, st_exec_program,
      st_exec_erase, st_exec_read, st_exec_set_feat, st_exec_get_feat,
      st_exec_status, st_exec_status_enh, st_exec_vol_select, st_exec_odt_cfg:
      begin
        if (exec_done)
        begin
          s_nxt.state = exec_to_read ? st_idle_read : st_idle;
        end
      end
      default:
      begin
        s_nxt.state = st_idle;
      end
    endcase

    // Idle entry actions
    if (s_nxt.state == st_idle && s_r.state != st_idle)
    begin
      s_nxt.copyback_active = 1'b0;
      s_nxt.resume_state    = st_idle;
    end
    if (s_nxt.state == st_idle_read && s_r.state != st_idle_read)
    begin
      s_nxt.resume_state = st_idle_read;
    end

    // Software control writes; sets win over hardware clears
    if (wr_ack && avs_address_i == NTI_REG_CTRL)
    begin
      s_nxt.column_change_allowed     = avs_writedata_i[NTI_CTRL_COL_CHG];
      s_nxt.column_change_enh_allowed = avs_writedata_i[NTI_CTRL_COL_CHG_ENH];
      s_nxt.selected_unit_index       = avs_writedata_i[NTI_CTRL_UNIT_LSB +: NTI_UNIT_IDX_W];
      if (avs_writedata_i[NTI_CTRL_COPYBACK])
      begin
        s_nxt.copyback_active = 1'b1;
      end
      if (avs_writedata_i[NTI_CTRL_ENH_REQ])
      begin
        s_nxt.enh_status_required = 1'b1;
      end
    end
  end

  // State register with power-on values
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s_r                           <= '0;
      s_r.state                     <= st_power_up;
      s_r.resume_state              <= st_idle;
      s_r.ready_busy                <= 1'b0;
      s_r.return_status_on_read     <= 1'b0;
      s_r.column_change_allowed     <= 1'b0;
      s_r.column_change_enh_allowed <= 1'b0;
      s_r.copyback_active           <= 1'b0;
      s_r.selected_unit_index       <= '0;
      s_r.enh_status_required       <= 1'b0;
      s_r.wp_meta                   <= 1'b1;
      s_r.wp_sync                   <= 1'b1;
      s_r.wp_seen                   <= 1'b1;
      s_r.wp_to_units               <= 1'b1;
      s_r.units_seen                <= '1;
      s_r.bus_wait                  <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata_o              = s_r.bus_rdata;
  assign avs_waitrequest_o           = s_r.bus_wait;
  assign ready_busy_o                = s_r.ready_busy;
  assign wp_level_to_units_o         = s_r.wp_to_units;
  assign return_status_on_read_o     = s_r.return_status_on_read;
  assign column_change_allowed_o     = s_r.column_change_allowed;
  assign column_change_enh_allowed_o = s_r.column_change_enh_allowed;
  assign copyback_active_o           = s_r.copyback_active;
  assign selected_unit_index_o       = s_r.selected_unit_index;
  assign last_opcode_record_o        = s_r.last_opcode_record;
  assign enh_status_required_o       = s_r.enh_status_required;
  assign state_o                     = s_r.state;

endmodule // nti_target_fsm
`default_nettype wire

// >>> verification/nti_target_fsm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nti_target_fsm_asserts
  import nti_pkg::*;
#(
  parameter int unsigned POWER_UP_CYCLES = 8
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire nti_cmd_s                 cmd_i,
  input  wire logic [NTI_NUM_UNITS-1:0] unit_ready_bit_i,
  input  wire logic                     ready_busy_o,
  input  wire logic                     wp_level_to_units_o,
  input  wire logic                     return_status_on_read_o,
  input  wire logic                     copyback_active_o,
  input  wire logic [7:0]               last_opcode_record_o,
  input  wire nti_state_e               state_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] pu_cnt_r;
  logic [7:0]  op_r;
  // Time spent in power-up, and the latest opcode sent
  always_ff @(posedge ref_clk_i)
  begin
    pu_cnt_r <= (rst_i || state_o != st_power_up) ? 32'h0 : pu_cnt_r + 32'h1;
    op_r     <= cmd_i.valid ? cmd_i.opcode : op_r;
  end
  a_pu_bound: assert property (pu_cnt_r <= POWER_UP_CYCLES + 1)
    else $error("power-up lasts too long");
  a_pu_busy: assert property (state_o == st_power_up |-> !ready_busy_o)
    else $error("ready during power-up");
  a_pur_ready: assert property (state_o == st_power_up_ready |-> ready_busy_o)
    else $error("busy in power-up ready");
  a_pur_hold: assert property (state_o == st_power_up_ready && !(cmd_i.valid && cmd_i.opcode == NTI_OP_RESET)
    |=> state_o == st_power_up_ready) else $error("power-up ready left without reset");
  a_pur_reset: assert property (state_o == st_power_up_ready && cmd_i.valid && cmd_i.opcode == NTI_OP_RESET
    |=> state_o == st_exec_rst_power_up) else $error("reset not taken in power-up ready");
  a_rb_and: assert property (state_o == st_readiness_update |=> ready_busy_o == &$past(unit_ready_bit_i))
    else $error("ready not AND of units");
  a_rb_resume: assert property (state_o == st_readiness_update |=> state_o inside {st_idle, st_idle_read})
    else $error("readiness update went astray");
  a_idle_copy: assert property (state_o == st_idle && $past(state_o) != st_idle |-> !copyback_active_o)
    else $error("copyback kept on idle entry");
  a_decode_flag: assert property (state_o == st_cmd_decode
    |=> return_status_on_read_o == (state_o inside {st_exec_status, st_exec_status_enh}))
    else $error("status flag wrong after decode");
  a_wp_source: assert property ($changed(wp_level_to_units_o) |-> $past(state_o) == st_wp_update)
    else $error("protect level moved outside its state");
  a_last_op: assert property (state_o == st_idle && cmd_i.valid && !(cmd_i.opcode inside {8'h70, 8'h78})
    |-> ##2 last_opcode_record_o == op_r) else $error("opcode not recorded");
  a_status_keep: assert property (state_o == st_idle && cmd_i.valid && cmd_i.opcode inside {8'h70, 8'h78}
    |=> $stable(last_opcode_record_o) [*2]) else $error("status read overwrote record");
  c_program: cover property (state_o == st_exec_program);
  c_ready: cover property (state_o == st_readiness_update);
  c_protect: cover property (state_o == st_wp_update);
endmodule // nti_target_fsm_asserts
`default_nettype wire

// >>> verification/nti_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nti_host_model
  import nti_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic ready_busy_i,
  output var nti_cmd_s cmd_o
);
  // Opcode lines carry junk outside a command cycle
  initial cmd_o = '{valid: 1'b0, opcode: 8'hA5};
  // One first command cycle after a pause
  task automatic issue(input logic [7:0] op, input int gap, input bit need_ready);
    repeat (gap) @(posedge ref_clk_i);
    if (need_ready)
    begin
      wait (ready_busy_i === 1'b1);
    end
    @(posedge ref_clk_i);
    cmd_o <= '{valid: 1'b1, opcode: op};
    @(posedge ref_clk_i);
    cmd_o <= '{valid: 1'b0, opcode: ~op};
  endtask
endmodule // nti_host_model
`default_nettype wire

// >>> verification/nand_target_idle_cmd_fsm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nand_target_idle_cmd_fsm_tb;
  import nti_pkg::*;
  localparam int unsigned POWER_UP_CYCLES = 8;
  logic        ref_clk_i;
  logic        rst_i;
  logic        wp_n_i;
  logic [3:0]  unit_ready_bit_i;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        ready_busy_o;
  logic        col_chg;
  logic        col_chg_enh;
  logic [3:0]  unit_idx;
  logic        enh_req;
  nti_cmd_s    cmd_i;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  int          bad_count;
  int          samples_checked;
  int          cycles;
  logic [7:0]  last_op;
  logic [31:0] ctrl;
  logic        stat;
  logic [7:0]  ops [15] = '{8'hFF, 8'hFC, 8'hFA, 8'h90, 8'hEC, 8'hED, 8'h80, 8'h60, 8'h00, 8'hEF, 8'hEE,
                            8'h70, 8'h78, 8'hE1, 8'hE2};
  nti_state_e  sts [15] = '{st_exec_reset, st_exec_reset_sync, st_exec_reset_unit, st_exec_read_id,
                            st_exec_param_page, st_exec_unique_id, st_exec_program, st_exec_erase, st_exec_read,
                            st_exec_set_feat, st_exec_get_feat, st_exec_status, st_exec_status_enh,
                            st_exec_vol_select, st_exec_odt_cfg};

  nti_target_fsm #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .wp_n_i(wp_n_i), .unit_ready_bit_i(unit_ready_bit_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ready_busy_o(ready_busy_o), .wp_level_to_units_o(), .return_status_on_read_o(),
    .column_change_allowed_o(col_chg), .column_change_enh_allowed_o(col_chg_enh), .copyback_active_o(),
    .selected_unit_index_o(unit_idx), .last_opcode_record_o(), .enh_status_required_o(enh_req), .state_o());
  nti_host_model u_host (.ref_clk_i(ref_clk_i), .ready_busy_i(ready_busy_o), .cmd_o(cmd_i));

  // Clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= d;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] stw(nti_state_e s, logic so, logic rb, logic wp, logic [7:0] op, nti_state_e rs);
    return {11'h0, rs, op, wp, rb, so, s};
  endfunction

  // Compare each answered read with the oldest note
  always @(posedge ref_clk_i)
  begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
      check(avs_readdata_o & mask_q.pop_front(), exp_q.pop_front());
  end

  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles > 4000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h9280b897));
    {bad_count, samples_checked, cycles} = '0;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    unit_ready_bit_i = 4'hF;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(NTI_REG_STATUS, stw(st_power_up, 1'b0, 1'b0, 1'b1, 8'h00, st_power_up), 32'h0000_FFFF);
    rd(NTI_REG_CTRL, 32'h0, 32'h0000_00FF);
    repeat (POWER_UP_CYCLES) @(posedge ref_clk_i);
    rd(NTI_REG_STATUS, stw(st_power_up_ready, 1'b0, 1'b1, 1'b1, 8'h00, st_power_up), 32'h7F);
    u_host.issue(8'h90, 0, 1'b1);
    rd(NTI_REG_STATUS, stw(st_power_up_ready, 1'b0, 1'b1, 1'b1, 8'h00, st_power_up), 32'h1F);
    u_host.issue(8'hFF, 0, 1'b1);
    rd(NTI_REG_STATUS, stw(st_exec_rst_power_up, 1'b0, 1'b1, 1'b1, 8'h00, st_power_up), 32'h1F);
    bus(1'b1, NTI_REG_CTRL, 32'h4);
    bus(1'b1, NTI_REG_EXEC, 32'h1);
    rd(NTI_REG_STATUS, stw(st_idle, 1'b0, 1'b1, 1'b1, 8'h00, st_idle), 32'h001F_001F);
    rd(NTI_REG_CTRL, 32'h0, 32'h4);
    $display("test power-up done");
    for (int i = 0; i < 15; i++)
    begin
      ctrl = {24'h0, 4'($urandom), 4'h8 | 4'($urandom_range(3))};
      bus(1'b1, NTI_REG_CTRL, ctrl);
      stat = ops[i] inside {8'h70, 8'h78};
      if (!stat)
        last_op = ops[i];
      u_host.issue(ops[i], $urandom_range(3), 1'b1);
      rd(NTI_REG_STATUS, stw(sts[i], stat, 1'b1, 1'b1, last_op, st_idle), 32'hFF3F);
      rd(NTI_REG_CTRL, {ctrl[31:4], !stat ? 1'b0 : 1'b1, ctrl[2:0]}, 32'hFB);
      check({24'h0, unit_idx, enh_req, 1'b0, col_chg_enh, col_chg}, {24'h0, ctrl[7:4], stat, 1'b0, ctrl[1:0]});
      bus(1'b1, NTI_REG_EXEC, 32'h1);
    end
    $display("test dispatch done");
    wp_n_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    rd(NTI_REG_STATUS, stw(st_idle, 1'b0, 1'b1, 1'b0, last_op, st_idle), 32'hFF);
    for (int i = 0; i < 2; i++)
    begin
      last_op = i ? 8'h60 : 8'h80;
      u_host.issue(last_op, $urandom_range(3), 1'b1);
      rd(NTI_REG_STATUS, stw(st_idle, 1'b0, 1'b1, 1'b0, last_op, st_idle), 32'hFFFF);
    end
    wp_n_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rd(NTI_REG_STATUS, stw(st_idle, 1'b0, 1'b1, 1'b1, last_op, st_idle), 32'h9F);
    $display("test protect done");
    unit_ready_bit_i <= 4'(~(4'h1 << $urandom_range(3)));
    repeat (4) @(posedge ref_clk_i);
    rd(NTI_REG_STATUS, stw(st_idle, 1'b0, 1'b0, 1'b1, last_op, st_idle), 32'hDF);
    fork
      u_host.issue(8'hEC, 0, 1'b1);
      begin
        repeat (6) @(posedge ref_clk_i);
        unit_ready_bit_i <= 4'hF;
      end
    join
    rd(NTI_REG_STATUS, stw(st_exec_param_page, 1'b0, 1'b1, 1'b1, 8'hEC, st_idle), 32'hFF5F);
    bus(1'b1, NTI_REG_EXEC, 32'h3);
    unit_ready_bit_i <= 4'h7;
    repeat (4) @(posedge ref_clk_i);
    rd(NTI_REG_STATUS, stw(st_idle_read, 1'b0, 1'b0, 1'b1, 8'hEC, st_idle_read), 32'h001F_005F);
    wp_n_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    rd(NTI_REG_STATUS, stw(st_idle_read, 1'b0, 1'b0, 1'b0, 8'hEC, st_idle_read), 32'h001F_00DF);
    $display("test readiness done");
    give_verdict();
  end
endmodule // nand_target_idle_cmd_fsm_tb

bind nti_target_fsm nti_target_fsm_asserts #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .unit_ready_bit_i(unit_ready_bit_i),
  .ready_busy_o(ready_busy_o), .wp_level_to_units_o(wp_level_to_units_o),
  .return_status_on_read_o(return_status_on_read_o), .copyback_active_o(copyback_active_o),
  .last_opcode_record_o(last_opcode_record_o), .state_o(state_o));
`default_nettype wire
